// File: common/pll_config_control_map.vh
// Constants for the PLL configuration control block
`ifndef PLL_CONFIG_CONTROL_MAP_VH
`define PLL_CONFIG_CONTROL_MAP_VH
`define PD_NORMAL      2'h0
`define PD_ASYNC       2'h1
`define PD_RESET       2'h1
`define CP_HIGHZ       2'h0
`define CP_NORMAL      2'h3
`define CP_PUMP_UP     2'h1
`define CP_PUMP_DOWN   2'h2
`define CP_MODE_RESET  2'h3
`define CP_CUR_RESET   3'h7
`define ABL_RESET      2'h0
`define REFSEL_SE      1'h0
`define REFSEL_DIFF    1'h1
`define CAL_STEP_INIT  6'h10
`define BAND_W         6
`define BAND_RESET     6'h20
`define BAND_MAX       6'h3F
`endif

// File: rtl/pll_config_control.v
// Register-driven control logic of an integer-N PLL synthesizer
// Overview of operation
// - Two-bit field selects antibacklash pulse width
// - Pump mode: high-Z, normal, up, down
// - Pump current in eight equal steps
// - Normal mode: detector drives pump up/down
// - Calibration picks VCO band for target
// - All reference receivers off after reset
// - Reference type chosen by reference control
// - Differential receiver off unless selected, enabled, PLL on
// - Single-ended buffer off on PLL or own down
// - Differential mode forces single-ended buffers off
// - Offset bit lowers single-ended bias point
// - Crystal enable turns on maintaining amplifier
// - Doubler presents twice reference frequency
// - Power-down field 00 normal, 01 reset default
// - Polarity bit flips detector sense, external VCO
`timescale 1ns/1ps
`default_nettype none
`include "pll_config_control_map.vh"
module pll_config_control #(
  parameter BAND_W = `BAND_W
) (
  input  wire              clk,              // 20 MHz clock
  input  wire              sys_rst,          // Synchronous reset, high
  input  wire              io_update,        // Apply staged settings pulse
  input  wire [1:0]        pll_pd_wr,        // Staged PLL power-down
  input  wire [1:0]        abl_width_wr,     // Staged antibacklash select
  input  wire [1:0]        cp_mode_wr,       // Staged pump mode
  input  wire [2:0]        cp_current_wr,    // Staged pump current
  input  wire              pfd_neg_wr,       // Staged detector polarity
  input  wire              ext_vco_wr,       // Staged external VCO use
  input  wire              ref_diff_wr,      // Staged differential select
  input  wire              ref_one_pd_wr,    // Staged reference_one down
  input  wire              ref_two_pd_wr,    // Staged reference_two down
  input  wire              ref_one_en_wr,    // Staged reference_one on
  input  wire              ref_two_en_wr,    // Staged reference_two on
  input  wire              ref_diff_en_wr,   // Staged differential on
  input  wire              se_offset_wr,     // Staged bias offset
  input  wire              crystal_amp_wr,   // Staged crystal amp enable
  input  wire              doubler_wr,       // Staged doubler enable
  input  wire              vco_cal_wr,       // Staged calibrate bit
  input  wire              ref_div_out,      // R divider output
  input  wire              fb_div_out,       // N divider output
  input  wire              vco_above,        // VCO above target, cal
  input  wire              reference_in,     // Reference before doubler
  output reg               pump_up_q,        // Pump up command
  output reg               pump_down_q,      // Pump down command
  output reg               pump_highz_q,     // Pump output high-Z
  output reg  [1:0]        abl_width_q,      // Antibacklash select
  output reg  [2:0]        cp_current_q,     // Pump current step
  output reg               pll_pd_q,         // PLL powered down
  output reg               diff_rx_pd_q,     // Differential rx down
  output reg               ref_one_pd_q,     // reference_one buffer down
  output reg               ref_two_pd_q,     // reference_two buffer down
  output reg               se_offset_q,      // Bias offset on
  output reg               crystal_amp_enable, // Maintaining amp on
  output reg               doubler_en_q,     // Doubler on
  output reg               ref_path_q,       // Reference to PLL path
  output reg  [BAND_W-1:0] vco_band_q,       // VCO tuning band
  output reg               cal_busy_q,       // Calibration in progress
  output reg               cal_done_q        // Calibration finished
);

  // Calibration sequencer states
  localparam [1:0] CAL_IDLE   = 2'h0;
  localparam [1:0] CAL_SEARCH = 2'h1;
  localparam [1:0] CAL_DONE   = 2'h2;

  // Applied copies of staged fields
  reg [1:0]        pd_q;
  reg [1:0]        mode_q;
  reg              neg_q;
  reg              ext_q;
  reg              diff_q;
  reg              one_pd_q;
  reg              two_pd_q;
  reg              one_en_q;
  reg              two_en_q;
  reg              diff_en_q;
  reg              cal_q;

  // Derived controls and their next values
  wire             pll_off;
  wire             pol_neg;
  wire             up_raw;
  wire             down_raw;
  wire             diff_sel;
  wire [1:0]       se_own_pd;
  wire [1:0]       se_own_en;
  wire [1:0]       se_pd_d;
  reg              pump_up_d;
  reg              pump_down_d;
  reg              pump_highz_d;
  reg              pll_pd_d;
  reg              diff_rx_pd_d;
  reg              ref_path_d;
  reg              ref_prev_q;

  // Calibration state and next values
  reg [1:0]        cal_state_q;
  reg [1:0]        cal_state_d;
  reg              cal_prev_q;
  reg [BAND_W-1:0] step_q;
  reg [BAND_W-1:0] step_d;
  reg [BAND_W-1:0] vco_band_d;
  reg              cal_busy_d;
  reg              cal_done_d;
  wire             cal_start;

  // Staged fields reach the applied copies only on io_update
  always @(posedge clk) begin
    if (sys_rst) begin
      pd_q         <= `PD_RESET;
      abl_width_q  <= `ABL_RESET;
      mode_q       <= `CP_MODE_RESET;
      cp_current_q <= `CP_CUR_RESET;
      neg_q        <= 1'b0;
      ext_q        <= 1'b0;
      diff_q       <= `REFSEL_SE;
      one_pd_q     <= 1'b0;
      two_pd_q     <= 1'b0;
      one_en_q     <= 1'b0;
      two_en_q     <= 1'b0;
      diff_en_q    <= 1'b0;
      se_offset_q  <= 1'b0;
      crystal_amp_enable <= 1'b0;
      doubler_en_q <= 1'b0;
      cal_q        <= 1'b0;
    end else if (io_update) begin
      pd_q         <= pll_pd_wr;
      abl_width_q  <= abl_width_wr;
      mode_q       <= cp_mode_wr;
      cp_current_q <= cp_current_wr;
      neg_q        <= pfd_neg_wr;
      ext_q        <= ext_vco_wr;
      diff_q       <= ref_diff_wr;
      one_pd_q     <= ref_one_pd_wr;
      two_pd_q     <= ref_two_pd_wr;
      one_en_q     <= ref_one_en_wr;
      two_en_q     <= ref_two_en_wr;
      diff_en_q    <= ref_diff_en_wr;
      se_offset_q  <= se_offset_wr;
      crystal_amp_enable <= crystal_amp_wr;
      doubler_en_q <= doubler_wr;
      cal_q        <= vco_cal_wr;
    end
  end

  // Only 00 runs the PLL; other codes hold it down
  assign pll_off  = (pd_q != `PD_NORMAL);
  // Polarity applies only with an external VCO
  assign pol_neg  = neg_q & ext_q;
  assign up_raw   = pol_neg ? fb_div_out : ref_div_out;
  assign down_raw = pol_neg ? ref_div_out : fb_div_out;
  assign diff_sel = (diff_q == `REFSEL_DIFF);

  // Pump and receiver next values
  always @* begin
    pll_pd_d     = pll_off;
    pump_highz_d = pll_off | (mode_q == `CP_HIGHZ);
    pump_up_d    = 1'h0;
    pump_down_d  = 1'h0;
    case (mode_q)
      `CP_NORMAL: begin
        // Both high clears as the antibacklash overlap
        pump_up_d   = ~pll_off & up_raw & ~down_raw;
        pump_down_d = ~pll_off & down_raw & ~up_raw;
      end
      `CP_PUMP_UP: begin
        pump_up_d   = ~pll_off;
        pump_down_d = 1'h0;
      end
      `CP_PUMP_DOWN: begin
        pump_up_d   = 1'h0;
        pump_down_d = ~pll_off;
      end
      default: begin
        pump_up_d   = 1'h0;
        pump_down_d = 1'h0;
      end
    endcase
    diff_rx_pd_d = pll_off | ~diff_sel | ~diff_en_q;
  end

  // Single-ended buffers, one per shared reference pin
  assign se_own_pd = {two_pd_q, one_pd_q};
  assign se_own_en = {two_en_q, one_en_q};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_se_buf
      assign se_pd_d[g] = pll_off | se_own_pd[g] | ~se_own_en[g]
                          | diff_sel;
    end
  endgenerate

  // Output flip-flops
  always @(posedge clk) begin
    if (sys_rst) begin
      // Every reference receiver stays off until the host enables it
      pump_up_q    <= 1'h0;
      pump_down_q  <= 1'h0;
      pump_highz_q <= 1'h1;
      pll_pd_q     <= 1'h1;
      diff_rx_pd_q <= 1'h1;
      ref_one_pd_q <= 1'h1;
      ref_two_pd_q <= 1'h1;
    end else begin
      pump_up_q    <= pump_up_d;
      pump_down_q  <= pump_down_d;
      pump_highz_q <= pump_highz_d;
      pll_pd_q     <= pll_pd_d;
      diff_rx_pd_q <= diff_rx_pd_d;
      ref_one_pd_q <= se_pd_d[0];
      ref_two_pd_q <= se_pd_d[1];
    end
  end

  // Doubler: a pulse on each edge of the reference doubles its rate
  always @* begin
    if (doubler_en_q)
      ref_path_d = reference_in ^ ref_prev_q;
    else
      ref_path_d = reference_in;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      ref_prev_q <= 1'h0;
      ref_path_q <= 1'h0;
    end else begin
      ref_prev_q <= reference_in;
      ref_path_q <= ref_path_d;
    end
  end

  // Calibration: binary search of the band on a rising calibrate bit
  assign cal_start = cal_q & ~cal_prev_q & ~pll_off;

  // Step halves each cycle, so the search ends in BAND_W-1 moves
  always @* begin
    cal_state_d = cal_state_q;
    step_d      = step_q;
    vco_band_d  = vco_band_q;
    cal_busy_d  = cal_busy_q;
    cal_done_d  = cal_done_q;
    case (cal_state_q)
      CAL_IDLE: begin
        if (cal_start) begin
          vco_band_d  = `BAND_RESET;
          step_d      = `CAL_STEP_INIT;
          cal_busy_d  = 1'h1;
          cal_done_d  = 1'h0;
          cal_state_d = CAL_SEARCH;
        end
      end
      CAL_SEARCH: begin
        if (step_q == {BAND_W{1'b0}}) begin
          cal_busy_d  = 1'h0;
          cal_done_d  = 1'h1;
          cal_state_d = CAL_DONE;
        end else begin
          // Step down while the VCO runs above target, else up
          if (vco_above)
            vco_band_d = vco_band_q - step_q;
          else
            vco_band_d = vco_band_q + step_q;
          step_d = step_q >> 1;
        end
      end
      CAL_DONE: begin
        // Wait for the host to clear the bit before rearming
        if (~cal_q)
          cal_state_d = CAL_IDLE;
      end
      default: cal_state_d = CAL_IDLE;
    endcase
  end

  // Calibration flip-flops
  always @(posedge clk) begin
    if (sys_rst) begin
      cal_state_q <= CAL_IDLE;
      cal_prev_q  <= 1'h0;
      vco_band_q  <= `BAND_RESET;
      step_q      <= `CAL_STEP_INIT;
      cal_busy_q  <= 1'h0;
      cal_done_q  <= 1'h0;
    end else begin
      cal_prev_q  <= cal_q;
      cal_state_q <= cal_state_d;
      step_q      <= step_d;
      vco_band_q  <= vco_band_d;
      cal_busy_q  <= cal_busy_d;
      cal_done_q  <= cal_done_d;
    end
  end

endmodule // pll_config_control
`default_nettype wire

// File: test/pll_config_control_sva.sv
// Assertion checker for the PLL configuration control block
`timescale 1ns/1ps
`default_nettype none
module pll_config_control_sva (
  input wire logic       clk,            // Clock
  input wire logic       sys_rst,        // Reset
  input wire logic       io_update,      // Apply
  input wire logic [1:0] pll_pd_wr,      // Staged
  input wire logic [1:0] abl_width_wr,   // Staged
  input wire logic       ref_diff_wr,    // Staged
  input wire logic       ref_diff_en_wr, // Staged
  input wire logic [1:0] abl_width_q,    // Applied
  input wire logic       pll_pd_q,       // Out
  input wire logic       diff_rx_pd_q,   // Out
  input wire logic       pump_up_q,      // Out
  input wire logic       pump_down_q,    // Out
  input wire logic       pump_highz_q,   // Out
  input wire logic       cal_busy_q,     // Out
  input wire logic       cal_done_q      // Out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_abl_load: assert property (
    io_update |=> abl_width_q == $past(abl_width_wr)) else $error("abl");
  a_abl_hold: assert property (
    !io_update |=> $stable(abl_width_q)) else $error("abl moved");
  a_pd_load: assert property (
    io_update |-> ##2 pll_pd_q == ($past(pll_pd_wr, 2) != 2'h0))
    else $error("pd");
  a_diff_pd: assert property (
    io_update |-> ##2 diff_rx_pd_q == ($past(pll_pd_wr, 2) != 2'h0 ||
      !$past(ref_diff_wr, 2) || !$past(ref_diff_en_wr, 2)))
    else $error("diff pd");
  a_pump_off: assert property (
    pll_pd_q |-> !pump_up_q && !pump_down_q && pump_highz_q)
    else $error("pump while down");
  a_pump_excl: assert property (
    pump_up_q |-> !pump_down_q) else $error("pump both");
  a_cal_end: assert property (
    $rose(cal_busy_q) |-> ##[1:8] (!cal_busy_q && cal_done_q))
    else $error("cal end");
  a_cal_refuse: assert property (
    pll_pd_q && $past(pll_pd_q) |-> !$rose(cal_busy_q))
    else $error("cal while down");
endmodule // pll_config_control_sva
bind pll_config_control pll_config_control_sva u_sva (.clk, .sys_rst,
  .io_update, .pll_pd_wr, .abl_width_wr, .ref_diff_wr, .ref_diff_en_wr,
  .abl_width_q, .pll_pd_q, .diff_rx_pd_q, .pump_up_q, .pump_down_q,
  .pump_highz_q, .cal_busy_q, .cal_done_q);
`default_nettype wire

// File: test/ref_source_model.sv
// Reference source and VCO comparator on the analog side
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
  parameter logic [5:0] TARGET = 6'h2B
) (
  input  wire logic       clk,          // Clock
  input  wire logic [1:0] fb_mode,      // 0 track, 1 low, 2 high
  input  wire logic [5:0] band,         // VCO band
  output var  logic       ref_div_out,  // Divided reference
  output var  logic       fb_div_out,   // Divided feedback
  output var  logic       reference_in, // Reference clock
  output var  logic       vco_above     // VCO above target
);
  logic [2:0] cnt_q = 3'h0;
  always @(posedge clk) cnt_q <= cnt_q + 3'h1;
  always_comb begin
    reference_in = cnt_q[0];
    ref_div_out  = cnt_q[2];
    fb_div_out   = (fb_mode == 2'h0) ? cnt_q[2] : (fb_mode == 2'h2);
    vco_above    = band > TARGET;
  end
endmodule // ref_source_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the PLL configuration control block
`timescale 1ns/1ps
`default_nettype none
`include "pll_config_control_map.vh"
module testbench;
  logic       clk = 1'h0, sys_rst = 1'h1, io_update = 1'h0, doubler_wr = 1'h0;
  logic       pfd_neg_wr = 1'h0, ext_vco_wr = 1'h0, ref_diff_wr = 1'h0;
  logic       ref_one_pd_wr = 1'h0, ref_two_pd_wr = 1'h0, vco_cal_wr = 1'h0;
  logic       ref_one_en_wr = 1'h0, ref_two_en_wr = 1'h0, se_offset_wr = 1'h0;
  logic       ref_diff_en_wr = 1'h0, crystal_amp_wr = 1'h0;
  logic [1:0] pll_pd_wr = `PD_ASYNC, abl_width_wr = 2'h0, cp_mode_wr = 2'h3;
  logic [1:0] fb_mode = 2'h0, abl_width_q;
  logic [2:0] cp_current_wr = 3'h0, cp_current_q;
  logic [5:0] vco_band_q;
  logic       ref_div_out, fb_div_out, vco_above, reference_in, pump_up_q;
  logic       pump_down_q, pump_highz_q, pll_pd_q, diff_rx_pd_q, ref_one_pd_q;
  logic       ref_two_pd_q, se_offset_q, crystal_amp_enable, doubler_en_q;
  logic       ref_path_q, cal_busy_q, cal_done_q;
  int         miscompares = 0, cmp_count = 0, i, n_up, n_dn;
  always #25 clk = ~clk;
  pll_config_control u_pll_config_control (.clk, .sys_rst, .io_update,
    .pll_pd_wr, .abl_width_wr, .cp_mode_wr, .cp_current_wr, .pfd_neg_wr,
    .ext_vco_wr, .ref_diff_wr, .ref_one_pd_wr, .ref_two_pd_wr, .ref_one_en_wr,
    .ref_two_en_wr, .ref_diff_en_wr, .se_offset_wr, .crystal_amp_wr,
    .doubler_wr, .vco_cal_wr, .ref_div_out, .fb_div_out, .vco_above,
    .reference_in, .pump_up_q, .pump_down_q, .pump_highz_q, .abl_width_q,
    .cp_current_q, .pll_pd_q, .diff_rx_pd_q, .ref_one_pd_q, .ref_two_pd_q,
    .se_offset_q, .crystal_amp_enable, .doubler_en_q, .ref_path_q,
    .vco_band_q, .cal_busy_q, .cal_done_q);
  ref_source_model u_ref_source_model (.clk, .fb_mode, .band(vco_band_q),
    .ref_div_out, .fb_div_out, .reference_in, .vco_above);
  task automatic check(input string nm, input logic [7:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic upd();
    @(negedge clk) io_update = 1'h1;
    @(negedge clk) io_update = 1'h0;
    @(negedge clk);
  endtask
  task automatic t_fields();
    abl_width_wr = 2'h3;
    repeat (3) @(negedge clk);
    check("staged", 8'h00, {6'h00, abl_width_q});
    for (i = 0; i < 8; i++) begin
      {doubler_wr, crystal_amp_wr, se_offset_wr} = i[2:0];
      abl_width_wr = i[1:0];
      cp_current_wr = 3'h7 - i[2:0];
      upd();
      check("fields", {i[1:0], 3'h7 - i[2:0], i[2:0]}, {abl_width_q,
        cp_current_q, doubler_en_q, crystal_amp_enable, se_offset_q});
    end
  endtask
  task automatic t_path(input logic en, input int exp);
    doubler_wr = en;
    upd();
    n_up = 0;
    repeat (8) begin
      @(negedge clk);
      if (ref_path_q === 1'h1) n_up++;
    end
    check("ref path", exp[7:0], n_up[7:0]);
  endtask
  task automatic t_refs();
    for (i = 0; i < 32; i++) begin
      pll_pd_wr = i[0] ? `PD_NORMAL : `PD_ASYNC;
      {ref_one_en_wr, ref_one_pd_wr, ref_diff_en_wr, ref_diff_wr} = i[4:1];
      {ref_two_en_wr, ref_two_pd_wr} = {i[4], ~i[3]};
      upd();
      check("ref pd", {5'h00, ~i[0] | ~i[1] | ~i[2],
        ~i[0] | i[3] | ~i[4] | i[1], ~i[0] | ~i[3] | ~i[4] | i[1]},
        {5'h00, diff_rx_pd_q, ref_one_pd_q, ref_two_pd_q});
    end
  endtask
  task automatic pump(input logic [1:0] pd, md, fm,
                      input logic neg, ext, input logic [2:0] exp);
    {pll_pd_wr, cp_mode_wr, fb_mode, pfd_neg_wr, ext_vco_wr} =
      {pd, md, fm, neg, ext};
    upd();
    n_up = 0;
    n_dn = 0;
    repeat (8) begin
      @(negedge clk);
      if (pump_up_q === 1'h1) n_up++;
      if (pump_down_q === 1'h1) n_dn++;
    end
    check("pump", {5'h00, exp}, {5'h00, n_up > 0, n_dn > 0, pump_highz_q});
  endtask
  task automatic t_cal();
    {pll_pd_wr, vco_cal_wr} = {`PD_ASYNC, 1'h1};
    upd();
    check("refused", 8'h00, {7'h00, cal_busy_q});
    repeat (2) begin
      {pll_pd_wr, vco_cal_wr} = {`PD_NORMAL, 1'h0};
      upd();
      vco_cal_wr = 1'h1;
      upd();
      for (i = 0; i < 4 && cal_busy_q !== 1'h1; i++) @(negedge clk);
      check("busy", 8'h01, {7'h00, cal_busy_q});
      for (i = 0; i < 20 && cal_done_q !== 1'h1; i++) @(negedge clk);
      if (i == 20) begin
        miscompares++;
        results();
      end
      check("band", 8'h01, {7'h00, vco_band_q >= 6'h2A &&
        vco_band_q <= 6'h2C});
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    check("reset pd", 8'h79, {1'h0, pll_pd_q, diff_rx_pd_q,
      ref_one_pd_q, ref_two_pd_q, pump_up_q, pump_down_q, pump_highz_q});
    check("reset cfg", 8'h38, {abl_width_q, cp_current_q, se_offset_q,
      crystal_amp_enable, doubler_en_q});
    sys_rst = 1'h0;
    t_fields();
    t_path(1'h0, 4);
    t_path(1'h1, 8);
    t_refs();
    pump(`PD_NORMAL, `CP_HIGHZ, 2'h1, 1'h0, 1'h0, 3'h1);
    pump(`PD_NORMAL, `CP_PUMP_UP, 2'h0, 1'h0, 1'h0, 3'h4);
    pump(`PD_NORMAL, `CP_PUMP_DOWN, 2'h0, 1'h0, 1'h0, 3'h2);
    pump(`PD_NORMAL, `CP_NORMAL, 2'h0, 1'h0, 1'h0, 3'h0);
    pump(`PD_NORMAL, `CP_NORMAL, 2'h1, 1'h0, 1'h0, 3'h4);
    pump(`PD_NORMAL, `CP_NORMAL, 2'h2, 1'h0, 1'h0, 3'h2);
    pump(`PD_NORMAL, `CP_NORMAL, 2'h1, 1'h1, 1'h1, 3'h2);
    pump(`PD_NORMAL, `CP_NORMAL, 2'h1, 1'h1, 1'h0, 3'h4);
    pump(`PD_ASYNC, `CP_PUMP_UP, 2'h0, 1'h0, 1'h0, 3'h1);
    t_cal();
    results();
  end
endmodule // testbench
`default_nettype wire
